// ---- hdl/pmco_pkg.sv ----
// constants and types shared by the pdm microphone output block
package pmco_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // system clock
  localparam int CLK_HZ = 20_000_000; // mclk rate

  ////////////////////////////////////////////////////////////////////////////
  // link clock frequency thresholds, in hertz as printed
  localparam int SLEEP_HZ = 200_000; // below this the part sleeps
  localparam int LP_LO_HZ = 400_000; // low edge of low-power band
  localparam int LP_HI_HZ = 800_000; // high edge of low-power band

  // the same thresholds as periods in mclk cycles
  localparam int SLEEP_CYC = CLK_HZ / SLEEP_HZ; // longest awake period
  localparam int LP_MAX_CYC = CLK_HZ / LP_LO_HZ; // slowest low-power period
  localparam int LP_MIN_CYC = CLK_HZ / LP_HI_HZ; // fastest low-power period

  // period counter width and saturation value
  localparam int PER_W = 8;
  localparam logic [PER_W-1:0] PER_SAT = PER_W'(SLEEP_CYC);
  localparam logic [PER_W-1:0] PER_LP_MAX = PER_W'(LP_MAX_CYC);
  localparam logic [PER_W-1:0] PER_LP_MIN = PER_W'(LP_MIN_CYC);
  localparam logic [PER_W-1:0] PER_RST = '0;

  ////////////////////////////////////////////////////////////////////////////
  // sleep entry and wake-up latencies, in milliseconds as printed
  localparam int SLEEP_ENTRY_MS = 1; // sleep entered within this
  localparam int WAKE_MS = 20; // output starts within this
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_MS * CYC_PER_MS;
  localparam int WAKE_CYC = WAKE_MS * CYC_PER_MS;
  // default settle time after the clock returns, half the limit
  localparam int SETTLE_CYC = WAKE_CYC / 2;
  localparam int SET_W = 20; // settle counter width

  ////////////////////////////////////////////////////////////////////////////
  // modulator sample format
  localparam int SMP_W = 16; // input sample width
  localparam int ACC_W = 18; // integrator width
  localparam logic signed [SMP_W-1:0] FULL_SCALE = 16'sh7fff;
  localparam logic signed [ACC_W-1:0] ACC_RST = '0;

  ////////////////////////////////////////////////////////////////////////////
  // power state, gray coded along sleep -> wake -> run
  typedef enum logic [1:0] {
    PMCO_SLEEP = 2'h0,
    PMCO_WAKE = 2'h1,
    PMCO_RUN = 2'h3
  } pmco_state_t;

endpackage

// ---- hdl/pmco_modulator.sv ----
// first-order one-bit density modulator with full-scale limiting
`timescale 1ns/1ps
module pmco_modulator (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clr,
  input wire logic step,
  input wire logic signed [pmco_pkg::SMP_W-1:0] sample,
  output logic bit_out
);

  logic signed [pmco_pkg::ACC_W-1:0] acc_ff; // integrator
  logic signed [pmco_pkg::ACC_W-1:0] nxt_acc; // integrator next
  logic signed [pmco_pkg::SMP_W-1:0] clip; // sample held to full scale
  logic signed [pmco_pkg::ACC_W-1:0] x_ext; // widened sample
  logic signed [pmco_pkg::ACC_W-1:0] fb; // quantiser feedback

  // the most negative code is pulled in so both peaks are symmetric
  assign clip = (sample < -pmco_pkg::FULL_SCALE) ?
    -pmco_pkg::FULL_SCALE : sample;
  assign x_ext = {{2{clip[pmco_pkg::SMP_W-1]}}, clip};
  // a one means the integrator is non-negative, ones follow amplitude
  assign bit_out = ~acc_ff[pmco_pkg::ACC_W-1];
  assign fb = bit_out ? {2'h0, pmco_pkg::FULL_SCALE}
    : -{2'h0, pmco_pkg::FULL_SCALE};
  assign nxt_acc = clr ? pmco_pkg::ACC_RST
    : step ? acc_ff + x_ext - fb : acc_ff;

  // integrator, advanced once per launched bit
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      acc_ff <= pmco_pkg::ACC_RST;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  // the clipped input never reaches beyond full scale
  AST_FS_LIMIT: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (clip <= pmco_pkg::FULL_SCALE) && (clip >= -pmco_pkg::FULL_SCALE))
    else $error("modulator input exceeds full scale");

  // zero input from a cleared integrator gives one then zero
  AST_ZERO_ALT: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (step && !clr && sample == '0 && acc_ff == '0) |=> !bit_out)
    else $error("zero input did not alternate");

endmodule

// ---- hdl/pmco_mic_out.sv ----
// pdm microphone output side: clock watch, power states, shared data pin
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Operation
// - 400 to 800 kHz clock selects low-power listening
// - clock below 200 kHz puts device asleep
// - asleep, data output stays high impedance
// - sleep reached within 1 ms of slowdown
// - output resumes within 20 ms of clock
// - start-up under 20 ms, first bit valid
// - sleeping or unpowered device never loads line
// - modulator density limited at digital full scale
// - select high left slot, low right slot
// - left launches on falling, right on rising
// - release driver after own half period
// - density of ones follows signal amplitude
module pmco_mic_out #(
  parameter int SETTLE_CYC = pmco_pkg::SETTLE_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic pdm_clk,
  input wire logic chan_select,
  input wire logic signed [pmco_pkg::SMP_W-1:0] audio_sample,
  output logic pdm_data_o,
  output logic pdm_data_oe,
  output logic low_power_listen_mode,
  output logic sleep_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: link clock in bit 0, select in bit 1
  logic [1:0] sy1_ff; // first stage, read only by sy2
  logic [1:0] sy2_ff; // second stage
  logic [1:0] sy3_ff; // third stage
  logic [1:0] lvl_ff; // accepted level
  logic [1:0] nxt_lvl; // accepted level next
  logic [1:0] agree; // second and third stage match
  logic clk_d_ff; // accepted link clock, one cycle late

  assign agree = ~(sy2_ff ^ sy3_ff);
  assign nxt_lvl = (agree & sy3_ff) | (~agree & lvl_ff);

  // three stages, level taken once stages two and three agree
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sy1_ff <= 2'h0;
      sy2_ff <= 2'h0;
      sy3_ff <= 2'h0;
      lvl_ff <= 2'h0;
      clk_d_ff <= 1'b0;
    end else begin
      sy1_ff <= {chan_select, pdm_clk};
      sy2_ff <= sy1_ff;
      sy3_ff <= sy2_ff;
      lvl_ff <= nxt_lvl;
      clk_d_ff <= lvl_ff[0];
    end
  end

  logic clk_rise; // link clock rising edge seen
  logic clk_fall; // link clock falling edge seen
  logic sel_left; // select high means left slot

  assign clk_rise = lvl_ff[0] & ~clk_d_ff;
  assign clk_fall = ~lvl_ff[0] & clk_d_ff;
  assign sel_left = lvl_ff[1];

  ////////////////////////////////////////////////////////////////////////////
  // link clock period measurement
  logic [pmco_pkg::PER_W-1:0] per_cnt_ff; // cycles since last rise
  logic [pmco_pkg::PER_W-1:0] nxt_per_cnt; // counter next
  logic [pmco_pkg::PER_W-1:0] period_ff; // last full period
  logic [pmco_pkg::PER_W-1:0] nxt_period; // period next
  logic clk_slow; // no rise for a sleep-length period
  logic in_lp_band; // last period inside low-power band

  assign clk_slow = (per_cnt_ff == pmco_pkg::PER_SAT);
  assign nxt_per_cnt = clk_rise ? pmco_pkg::PER_RST
    : clk_slow ? per_cnt_ff : per_cnt_ff + pmco_pkg::PER_W'(1);
  // count restarts at zero after a rise, so a full period is one more
  assign nxt_period = clk_rise ? per_cnt_ff + pmco_pkg::PER_W'(1)
    : period_ff;
  // between the sleep limit and the band the part is simply awake
  assign in_lp_band = (period_ff >= pmco_pkg::PER_LP_MIN) &&
    (period_ff <= pmco_pkg::PER_LP_MAX);

  // counter saturates so a stopped clock reads as slow
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      per_cnt_ff <= pmco_pkg::PER_SAT;
      period_ff <= pmco_pkg::PER_SAT;
    end else begin
      per_cnt_ff <= nxt_per_cnt;
      period_ff <= nxt_period;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power state machine
  pmco_pkg::pmco_state_t st_ff; // current power state
  pmco_pkg::pmco_state_t nxt_st; // power state next
  logic [pmco_pkg::SET_W-1:0] set_cnt_ff; // settle counter
  logic [pmco_pkg::SET_W-1:0] nxt_set_cnt; // settle counter next
  logic settled; // settle time elapsed

  assign settled = (set_cnt_ff >= pmco_pkg::SET_W'(SETTLE_CYC - 1));
  assign nxt_set_cnt = (st_ff == pmco_pkg::PMCO_WAKE) ?
    set_cnt_ff + pmco_pkg::SET_W'(1) : '0;

  // slow clock always wins; waking needs a live clock then settling
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      pmco_pkg::PMCO_SLEEP: begin
        if (!clk_slow && clk_rise) begin
          nxt_st = pmco_pkg::PMCO_WAKE;
        end
      end
      pmco_pkg::PMCO_WAKE: begin
        if (clk_slow) begin
          nxt_st = pmco_pkg::PMCO_SLEEP;
        end else if (settled) begin
          nxt_st = pmco_pkg::PMCO_RUN;
        end
      end
      pmco_pkg::PMCO_RUN: begin
        if (clk_slow) begin
          nxt_st = pmco_pkg::PMCO_SLEEP;
        end
      end
      default: begin
        nxt_st = pmco_pkg::PMCO_SLEEP;
      end
    endcase
  end

  // reset is power-up: start asleep, wake like any return of clock
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= pmco_pkg::PMCO_SLEEP;
      set_cnt_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      set_cnt_ff <= nxt_set_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit launch and release on the shared data line
  logic running; // output stage enabled
  logic own_edge; // edge on which this slot launches
  logic other_edge; // edge on which the other slot launches
  logic launch; // drive a fresh bit now
  logic mod_bit; // modulator's pending bit
  logic dout_ff; // data pin level
  logic doe_ff; // data pin enable
  logic nxt_dout; // data next
  logic nxt_doe; // enable next
  logic lp_ff; // low-power flag
  logic sleep_ff; // sleep flag

  assign running = (nxt_st == pmco_pkg::PMCO_RUN);
  assign own_edge = sel_left ? clk_fall : clk_rise;
  assign other_edge = sel_left ? clk_rise : clk_fall;
  assign launch = running && own_edge;
  assign nxt_dout = launch ? mod_bit : dout_ff;
  // never drive unless running; let go on the other slot's edge
  assign nxt_doe = !running ? 1'b0
    : launch ? 1'b1
    : other_edge ? 1'b0 : doe_ff;

  // modulator runs only while bits go out, cleared while asleep
  pmco_modulator u_mod (
    .mclk(mclk),
    .rst_b(rst_b),
    .clr(st_ff == pmco_pkg::PMCO_SLEEP),
    .step(launch),
    .sample(audio_sample),
    .bit_out(mod_bit)
  );

  // output flops, every top output straight from here
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dout_ff <= 1'b0;
      doe_ff <= 1'b0;
      lp_ff <= 1'b0;
      sleep_ff <= 1'b1;
    end else begin
      dout_ff <= nxt_dout;
      doe_ff <= nxt_doe;
      lp_ff <= (nxt_st != pmco_pkg::PMCO_SLEEP) && in_lp_band;
      sleep_ff <= (nxt_st == pmco_pkg::PMCO_SLEEP);
    end
  end

  assign pdm_data_o = dout_ff;
  assign pdm_data_oe = doe_ff;
  assign low_power_listen_mode = lp_ff;
  assign sleep_mode = sleep_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checking helpers: ages of slow clock while awake, and of waking
  logic [pmco_pkg::SET_W-1:0] slow_age_ff; // awake cycles with slow clock
  logic [pmco_pkg::SET_W-1:0] wake_age_ff; // cycles spent waking

  // both counters clear when their condition drops
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      slow_age_ff <= '0;
      wake_age_ff <= '0;
    end else begin
      slow_age_ff <= (clk_slow && st_ff != pmco_pkg::PMCO_SLEEP) ?
        slow_age_ff + pmco_pkg::SET_W'(1) : '0;
      wake_age_ff <= (st_ff == pmco_pkg::PMCO_WAKE) ?
        wake_age_ff + pmco_pkg::SET_W'(1) : '0;
    end
  end

  AST_SLEEP_HIZ: assert property (
    @(posedge mclk) disable iff (!rst_b)
    sleep_ff |-> !doe_ff)
    else $error("data driven while asleep");

  AST_LP_BAND: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (st_ff == pmco_pkg::PMCO_RUN && !clk_slow && in_lp_band)
      |=> low_power_listen_mode)
    else $error("low-power mode missed in band");

  AST_SLOW_SLEEP: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (clk_slow && st_ff != pmco_pkg::PMCO_SLEEP)
      |=> sleep_mode && st_ff == pmco_pkg::PMCO_SLEEP)
    else $error("slow clock did not cause sleep");

  AST_SLEEP_ENTRY: assert property (
    @(posedge mclk) disable iff (!rst_b)
    slow_age_ff < pmco_pkg::SET_W'(pmco_pkg::SLEEP_ENTRY_CYC))
    else $error("sleep entry too late");

  AST_WAKE_BOUND: assert property (
    @(posedge mclk) disable iff (!rst_b)
    wake_age_ff < pmco_pkg::SET_W'(pmco_pkg::WAKE_CYC))
    else $error("wake-up too slow");

  AST_LAUNCH: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (launch) |=> pdm_data_oe && (pdm_data_o == $past(mod_bit)))
    else $error("bit not launched on own edge");

  AST_LEFT_EDGE: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (running && sel_left && clk_rise) |=> !pdm_data_oe ##1 !launch)
    else $error("left slot drove on rising edge");

  AST_RELEASE: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (running && other_edge) |=> !pdm_data_oe)
    else $error("driver not released on other edge");

endmodule

// ---- test/pmco_host_model.sv ----
// host codec model: bit clock source, line resolver, per-slot sampler
`timescale 1ns/1ps
module pmco_host_model (
  input wire logic run,
  input wire logic [15:0] half_ns,
  input wire logic sel,
  input wire logic pdm_data_o,
  input wire logic pdm_data_oe,
  output logic pdm_clk,
  output logic line,
  output int ones,
  output int bits,
  output int floats,
  output int clashes
);
  logic last_lvl; // last driven level, the line has no pull

  ////////////////////////////////////////////////////////////////////////////
  // bit clock, stands low while stopped, odd phase against mclk
  initial begin
    pdm_clk = 1'b0;
    #13;
    forever begin
      if (run) begin
        #(half_ns);
        pdm_clk = ~pdm_clk;
      end else begin
        pdm_clk = 1'b0;
        #50;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // undriven line shows the inverse of the last driven level
  initial last_lvl = 1'b0;
  always @(pdm_data_o or pdm_data_oe) begin
    if (pdm_data_oe) begin
      last_lvl = pdm_data_o;
    end
  end
  assign line = pdm_data_oe ? pdm_data_o : ~last_lvl;

  ////////////////////////////////////////////////////////////////////////////
  // sample own slot at its closing edge, watch the other half for drive
  always @(pdm_clk) begin
    if (pdm_clk === sel) begin
      bits = bits + 1;
      ones = ones + int'(line);
      if (pdm_data_oe !== 1'b1) begin
        floats = floats + 1;
      end
    end else if (pdm_data_oe !== 1'b0) begin
      clashes = clashes + 1;
    end
  end
endmodule

// ---- test/test_pdm_mic_clock_mode_output.sv ----
// self-checking bench for the pdm microphone output block
`timescale 1ns/1ps
module test_pdm_mic_clock_mode_output;
  localparam int SETTLE = 40; // shortened wake settle time
  logic mclk; // system clock
  logic rst_b; // power-up reset
  logic run; // link clock enable
  logic [15:0] half_ns; // link half period
  logic chan_select; // slot select
  logic signed [pmco_pkg::SMP_W-1:0] audio_sample; // front-end sample
  logic pdm_clk; // link clock
  logic pdm_data_o; // data pin level
  logic pdm_data_oe; // data pin enable
  logic low_power_listen_mode; // mode flag
  logic sleep_mode; // sleep flag
  logic line; // resolved data line
  int ones; // sampled ones
  int bits; // sampled bits
  int floats; // samples with no driver
  int clashes; // drive in the other half
  int fails; // mismatch count
  int checks_done; // comparison count
  int cyc; // timeout counter

  pmco_mic_out #(.SETTLE_CYC(SETTLE)) pmco_mic_out_inst (
    .mclk(mclk),
    .rst_b(rst_b),
    .pdm_clk(pdm_clk),
    .chan_select(chan_select),
    .audio_sample(audio_sample),
    .pdm_data_o(pdm_data_o),
    .pdm_data_oe(pdm_data_oe),
    .low_power_listen_mode(low_power_listen_mode),
    .sleep_mode(sleep_mode)
  );

  pmco_host_model pmco_host_model_inst (
    .run(run),
    .half_ns(half_ns),
    .sel(chan_select),
    .pdm_data_o(pdm_data_o),
    .pdm_data_oe(pdm_data_oe),
    .pdm_clk(pdm_clk),
    .line(line),
    .ones(ones),
    .bits(bits),
    .floats(floats),
    .clashes(clashes)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 80000) begin // hang cut short
      fails = fails + 1;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic report_and_stop();
    if (fails == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk_bit(input string name, input logic e, input logic g);
    checks_done = checks_done + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("ERROR %s expected %b seen %b", name, e, g);
    end
  endtask
  task automatic chk_range(input string name, input int lo, input int hi,
                           input int g);
    checks_done = checks_done + 1;
    if (g < lo || g > hi) begin
      fails = fails + 1;
      $display("ERROR %s expected %0d..%0d seen %0d", name, lo, hi, g);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  function automatic logic sig_of(input int which);
    if (which == 0) begin
      return sleep_mode;
    end
    return pdm_data_oe;
  endfunction
  // bounded wait for a flag, then compare it
  task automatic wait_lvl(input string name, input int which,
                          input logic lvl, input int lim);
    int n;
    n = 0;
    while (sig_of(which) !== lvl && n < lim) begin
      wait_cyc(1);
      n++;
    end
    chk_bit(name, lvl, sig_of(which));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_startup();
    chk_bit("sleep_mode", 1'b1, sleep_mode);
    chk_bit("pdm_data_oe", 1'b0, pdm_data_oe);
    run = 1'b1;
    wait_lvl("sleep_mode", 0, 1'b0, 600);
    wait_lvl("pdm_data_oe", 1, 1'b1, 200);
  endtask
  task automatic t_band();
    logic [15:0] hv[5];
    logic ev[5];
    hv = '{16'h00c8, 16'h0258, 16'h0271, 16'h03e8, 16'h04e2};
    ev = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    for (int i = 0; i < 5; i++) begin
      half_ns = hv[i];
      wait_cyc(int'(hv[i]) * 8 / 50 + 20);
      chk_bit("low_power_listen_mode", ev[i], low_power_listen_mode);
    end
  endtask
  task automatic t_density();
    logic signed [pmco_pkg::SMP_W-1:0] sv[4];
    int o0, b0, f0, c0, v, e;
    sv = '{pmco_pkg::FULL_SCALE, 16'sh8000, 16'sh0000, 16'sh4000};
    half_ns = 16'h03e8;
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 4; k++) begin
        chan_select = (s == 0);
        audio_sample = sv[k];
        wait_cyc(200);
        o0 = ones;
        b0 = bits;
        f0 = floats;
        c0 = clashes;
        wait_cyc(1600);
        v = (int'(sv[k]) < -32767) ? -32767 : int'(sv[k]);
        e = (bits - b0) * (v + 32768) / 65536;
        chk_range("ones", e - 2, e + 2, ones - o0);
        chk_range("floats", 0, 0, floats - f0);
        chk_range("clashes", 0, 0, clashes - c0);
      end
    end
  endtask
  task automatic t_sleep();
    int n;
    half_ns = 16'h0bb8;
    wait_lvl("sleep_mode", 0, 1'b1, pmco_pkg::SLEEP_ENTRY_CYC);
    n = 0;
    repeat (400) begin
      wait_cyc(1);
      n = n + int'(pdm_data_oe !== 1'b0);
    end
    chk_range("drive in sleep", 0, 0, n);
    run = 1'b0;
    wait_cyc(300);
    chk_bit("sleep_mode", 1'b1, sleep_mode);
    run = 1'b1;
    half_ns = 16'h00c8;
    wait_lvl("sleep_mode", 0, 1'b0, 600);
    wait_lvl("pdm_data_oe", 1, 1'b1, 200);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_b = 1'b0;
    run = 1'b0;
    half_ns = 16'h00c8;
    chan_select = 1'b1;
    audio_sample = 16'sh0000;
    repeat (6) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    t_startup();
    t_band();
    t_density();
    t_sleep();
    report_and_stop();
  end
endmodule
